// ---- dac_ctrl_pkg.sv ----
// Functional notes
// - reset clears code, output held at zero
// - command bit 0 set means power setting
// - power setting applied after lsb acknowledge
// - mode bits decode into five power settings
// - reset leaves low power mode, bits 000
// - data updates keep low power/fast settling
// - data update leaves every powered down mode
// - command 0000 0001 stores setting in temp
// - code register preserved while powered down
// - high speed master code is not acknowledged
// - command 0001 0000 streams byte pairs, acked while the queue has room
`default_nettype none
package dac_ctrl_pkg;

  // ----------------------------------------------------------------
  // serial framing
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_LAST       = 4'h8;
  localparam logic [5:0] DEV_ADDR_HI    = 6'h26;   // 100 110, a0 pin below
  localparam logic [7:0] HS_MASTER_CODE = 8'h08;
  localparam logic [1:0] IDX_ADDR       = 2'h0;
  localparam logic [1:0] IDX_CMD        = 2'h1;
  localparam logic [1:0] IDX_MSB        = 2'h2;
  localparam logic [1:0] IDX_LSB        = 2'h3;

  // ----------------------------------------------------------------
  // command byte fields
  // ----------------------------------------------------------------
  localparam int         CMD_PWR_BIT    = 0;
  localparam int         CMD_LOAD_LSB   = 4;
  localparam logic [1:0] LOAD_STORE     = 2'h0;
  localparam logic [1:0] LOAD_FROM_TEMP = 2'h2;

  // ----------------------------------------------------------------
  // queued word and power modes
  // ----------------------------------------------------------------
  localparam int          WORD_W         = 17;
  localparam int          WORD_PWR_BIT   = 16;
  localparam int          MODE_WORD_LSB  = 13;
  localparam int          FIFO_DEPTH     = 16;
  localparam logic [15:0] DAC_RESET      = 16'h0000;
  localparam logic [2:0]  MODE_LOW_POWER = 3'h0;
  localparam logic [2:0]  MODE_FAST      = 3'h1;
  localparam logic [1:0]  PD_1K          = 2'h1;
  localparam logic [1:0]  PD_100K        = 2'h2;
  localparam logic [1:0]  PD_HI_Z        = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RECV = 4'h2,
    ST_ACK  = 4'h4,
    ST_SKIP = 4'h8
  } slave_state_t;

  // upper two mode bits non-zero means a powered down setting
  function automatic logic is_powered_down(input logic [2:0] mode);
    is_powered_down = (mode[2:1] != 2'h0);
  endfunction

endpackage
`default_nettype wire

// ---- line_events_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface line_events_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;
  modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface
`default_nettype wire

// ---- line_events.sv ----
`timescale 1ns/1ps
`default_nettype none
module line_events (
  input  wire logic      clk_in,
  input  wire logic      rst_b_in,
  input  wire logic      scl_in,
  input  wire logic      sda_in,
  line_events_if.src     ev
);

  logic scl_q;
  logic scl_d;
  logic sda_q;
  logic sda_d;

  // ----------------------------------------------------------------
  // previous line levels, idle high after reset
  // ----------------------------------------------------------------
  always_comb begin
    scl_d = scl_in;
    sda_d = sda_in;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // edges and bus conditions; data only moves while the clock is low
  assign ev.scl_rise = scl_in & ~scl_q;
  assign ev.scl_fall = ~scl_in & scl_q;
  assign ev.start    = scl_in & scl_q & sda_q & ~sda_in;
  assign ev.stop     = scl_in & scl_q & ~sda_q & sda_in;
  assign ev.sda      = sda_in;

endmodule
`default_nettype wire

// ---- sync_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_b_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // ----------------------------------------------------------------
  // pointers and fill count
  // ----------------------------------------------------------------
  assign in_ready_out  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  // wrap explicitly so a depth that is not a power of two still works
  always_comb begin
    wr_d  = wr_q;
    rd_d  = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage needs no reset; empty flag hides stale words
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end

endmodule
`default_nettype wire

// ---- dac_ctrl.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl
  import dac_ctrl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        a0_in,
  input  wire logic        conv_ready_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  output logic      [15:0] dac_code_out,
  output logic             update_out,
  output logic      [2:0]  mode_out,
  output logic             powered_down_mode_out,
  output logic             fast_settle_out,
  output logic             term_1k_out,
  output logic             term_100k_out,
  output logic             hi_z_out,
  output logic             addressed_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  line_events_if ev ();

  // serial byte sequencer
  slave_state_t      state_q;
  slave_state_t      state_d;
  logic [3:0]        cnt_q;
  logic [3:0]        cnt_d;
  logic [1:0]        idx_q;
  logic [1:0]        idx_d;
  logic [7:0]        shift_q;
  logic [7:0]        shift_d;
  logic [7:0]        cmd_q;
  logic [7:0]        cmd_d;
  logic [7:0]        msb_q;
  logic [7:0]        msb_d;
  logic              ack_q;
  logic              ack_d;
  logic              byte_ok;
  logic [1:0]        load_sel;
  logic [WORD_W-1:0] new_word;

  // store-only commands park a word here until an update command
  logic              temp_store;
  logic [WORD_W-1:0] temp_q;
  logic [WORD_W-1:0] temp_d;

  // queue handshake on both sides
  logic              push_valid;
  logic [WORD_W-1:0] push_word;
  logic              push_ready;
  logic              pop_valid;
  logic [WORD_W-1:0] pop_word;
  logic              drain;

  // converter-facing registers
  logic [15:0]       dac_q;
  logic [15:0]       dac_d;
  logic [2:0]        mode_q;
  logic [2:0]        mode_d;
  logic              upd_q;
  logic              upd_d;

  // ----------------------------------------------------------------
  // line conditions and queue toward the converter
  // ----------------------------------------------------------------
  // edges are found by comparing each sample with the previous one
  line_events u_events (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .ev       (ev.src)
  );

  // the queue lets the analog side hold off updates; when it is full the
  // lsb of a pair for an update command is refused, so the master sees the stall as a nack
  sync_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (clk_in),
    .rst_b_in      (rst_b_in),
    .in_valid_in   (push_valid),
    .in_ready_out  (push_ready),
    .in_data_in    (push_word),
    .out_valid_out (pop_valid),
    .out_ready_in  (conv_ready_in),
    .out_data_out  (pop_word)
  );

  // ----------------------------------------------------------------
  // byte acceptance
  // ----------------------------------------------------------------
  // command bits 5:4 pick store, update from temp, or write and update
  assign load_sel = cmd_q[CMD_LOAD_LSB +: 2];
  assign new_word = {cmd_q[CMD_PWR_BIT], msb_q, shift_q};

  // decide ack for the byte just shifted in
  always_comb begin
    byte_ok = 1'b0;
    unique case (idx_q)
      IDX_ADDR: begin
        // master code never matches, so it falls through unacknowledged
        byte_ok = (shift_q != HS_MASTER_CODE)
                  && (shift_q[7:1] == {DEV_ADDR_HI, a0_in})
                  && !shift_q[0];
      end
      IDX_CMD, IDX_MSB: begin
        // the msb needs no room yet; a pair is queued only at its lsb
        byte_ok = 1'b1;
      end
      IDX_LSB: begin
        // store-only commands bypass the queue and never stall
        byte_ok = (load_sel == LOAD_STORE) || push_ready;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // slave sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    idx_d      = idx_q;
    shift_d    = shift_q;
    cmd_d      = cmd_q;
    msb_d      = msb_q;
    ack_d      = ack_q;
    push_valid = 1'b0;
    push_word  = new_word;
    temp_store = 1'b0;
    // stop and start win over whatever the sequencer was doing
    if (ev.stop) begin
      state_d = ST_IDLE;
      ack_d   = 1'b0;
    end else if (ev.start) begin
      // a repeated start after the master code lands here too
      state_d = ST_RECV;
      cnt_d   = 4'h0;
      idx_d   = IDX_ADDR;
      ack_d   = 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE, ST_SKIP: begin
          // wait for the next start or stop; nothing on the line is shifted
          state_d = state_q;
        end
        ST_RECV: begin
          // eight rising edges fill the shift register; the ninth clock is the ack
          if (ev.scl_rise && cnt_q != BIT_LAST) begin
            shift_d = {shift_q[6:0], ev.sda};
            cnt_d   = cnt_q + 4'h1;
          end else if (ev.scl_fall && cnt_q == BIT_LAST) begin
            if (byte_ok) begin
              ack_d   = 1'b1;
              state_d = ST_ACK;
            end else begin
              state_d = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          // falling edge closing the acknowledge clock
          if (ev.scl_fall) begin
            ack_d   = 1'b0;
            cnt_d   = 4'h0;
            state_d = ST_RECV;
            unique case (idx_q)
              IDX_ADDR: begin
                // address accepted; the command byte comes next
                idx_d = IDX_CMD;
              end
              IDX_CMD: begin
                // the command stays for the whole frame so streamed pairs repeat it
                cmd_d = shift_q;
                idx_d = IDX_MSB;
              end
              IDX_MSB: begin
                msb_d = shift_q;
                idx_d = IDX_LSB;
              end
              IDX_LSB: begin
                idx_d = IDX_MSB;
                if (load_sel == LOAD_STORE) begin
                  temp_store = 1'b1;
                end else if (load_sel == LOAD_FROM_TEMP) begin
                  push_valid = 1'b1;
                  push_word  = temp_q;
                end else begin
                  push_valid = 1'b1;
                end
              end
            endcase
          end
        end
      endcase
    end
  end

  // sequencer registers; reset leaves the slave idle and the line released
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      state_q <= ST_IDLE;
      cnt_q   <= 4'h0;
      idx_q   <= IDX_ADDR;
      shift_q <= 8'h00;
      cmd_q   <= 8'h00;
      msb_q   <= 8'h00;
      ack_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      idx_q   <= idx_d;
      shift_q <= shift_d;
      cmd_q   <= cmd_d;
      msb_q   <= msb_d;
      ack_q   <= ack_d;
    end
  end

  // ----------------------------------------------------------------
  // temporary holding register
  // ----------------------------------------------------------------
  // holds either a code or a power setting until a later update command
  always_comb begin
    temp_d = temp_store ? new_word : temp_q;
  end

  // reset value mirrors the converter register: zero code, no power flag
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      temp_q <= {1'b0, DAC_RESET};
    end else begin
      temp_q <= temp_d;
    end
  end

  // ----------------------------------------------------------------
  // converter register and power setting
  // ----------------------------------------------------------------
  // the converter side takes one word per cycle while ready is high
  assign drain = pop_valid & conv_ready_in;

  // a queued word either carries a code or a power setting, never both
  always_comb begin
    dac_d  = dac_q;
    mode_d = mode_q;
    upd_d  = 1'b0;
    if (drain) begin
      if (pop_word[WORD_PWR_BIT]) begin
        // only the top three bits count; the low bits are don't care
        mode_d = pop_word[MODE_WORD_LSB +: 3];
      end else begin
        dac_d = pop_word[15:0];
        upd_d = 1'b1;
        if (is_powered_down(mode_q)) begin
          mode_d = MODE_LOW_POWER;
        end
        // low power and fast settling ride through data updates
      end
    end
  end

  // code is never touched by a power setting, so it survives power-down
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dac_q  <= DAC_RESET;
      mode_q <= MODE_LOW_POWER;
      upd_q  <= 1'b0;
    end else begin
      dac_q  <= dac_d;
      mode_q <= mode_d;
      upd_q  <= upd_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open drain: only ever pull low, during an acknowledge
  assign sda_out               = 1'b0;
  assign sda_oe_out            = ack_q;
  assign dac_code_out          = dac_q;
  assign update_out            = upd_q;
  assign mode_out              = mode_q;
  // decoded pins follow the registered mode, so a drain never glitches them
  assign powered_down_mode_out = is_powered_down(mode_q);
  assign fast_settle_out       = (mode_q == MODE_FAST);
  assign term_1k_out           = (mode_q[2:1] == PD_1K);
  assign term_100k_out         = (mode_q[2:1] == PD_100K);
  assign hi_z_out              = (mode_q[2:1] == PD_HI_Z);
  // high from the address acknowledge until a stop, start or refused byte
  assign addressed_out         = (state_q == ST_ACK) || (state_q == ST_RECV && idx_q != IDX_ADDR);

endmodule
`default_nettype wire

// ---- dac_ctrl_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_chk (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        scl_in,
  input  wire logic        conv_ready_in,
  input  wire logic        sda_oe_out,
  input  wire logic [15:0] dac_code_out,
  input  wire logic        update_out,
  input  wire logic [2:0]  mode_out,
  input  wire logic        powered_down_mode_out,
  input  wire logic        fast_settle_out,
  input  wire logic        term_1k_out,
  input  wire logic        term_100k_out,
  input  wire logic        hi_z_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  // ----------------------------------------
  // reset, code and mode
  // ----------------------------------------
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_b_in |=> dac_code_out == 16'h0000 && mode_out == 3'h0 && !update_out && !sda_oe_out)
    else $error("outputs not cleared by reset");
  a_code_needs_update: assert property (
    !$stable(dac_code_out) |-> update_out) else $error("code moved without update pulse");
  a_fast_decode: assert property (
    fast_settle_out == (mode_out == 3'h1)) else $error("fast settling decode wrong");
  a_down_decode: assert property (
    {powered_down_mode_out, term_1k_out, term_100k_out, hi_z_out} ==
    {mode_out[2:1] != 2'h0, mode_out[2:1] == 2'h1, mode_out[2:1] == 2'h2, mode_out[2:1] == 2'h3})
    else $error("powered down decode wrong");
  a_update_wakes: assert property (
    update_out |-> !powered_down_mode_out) else $error("update left device powered down");
  a_update_keeps: assert property (
    update_out && !$past(powered_down_mode_out) |-> $stable(mode_out)) else $error("update changed mode");

  // ----------------------------------------
  // acknowledge timing on the wire
  // ----------------------------------------
  // ack must never move while the serial clock is high
  a_ack_scl_low: assert property (
    $rose(sda_oe_out) |-> !scl_in) else $error("ack raised with clock high");
  a_ack_stands: assert property (
    $rose(scl_in) && sda_oe_out |=> sda_oe_out [*3]) else $error("ack dropped during clock high");

  cover property (update_out);
  cover property ($rose(powered_down_mode_out));
  cover property ($rose(sda_oe_out) && !conv_ready_in);
endmodule

bind dac_ctrl dac_ctrl_chk u_dac_ctrl_chk (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_in), .conv_ready_in(conv_ready_in),
  .sda_oe_out(sda_oe_out), .dac_code_out(dac_code_out), .update_out(update_out),
  .mode_out(mode_out), .powered_down_mode_out(powered_down_mode_out),
  .fast_settle_out(fast_settle_out), .term_1k_out(term_1k_out),
  .term_100k_out(term_100k_out), .hi_z_out(hi_z_out));
`default_nettype wire

// ---- i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_out,
  output var logic  sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // four slow cycles a level, so the slave always sees at least four samples
  task automatic half();
    repeat (4) @(negedge clk_in);
  endtask
  // start and repeated start: data falls while the clock is high
  task automatic start();
    sda_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_out = 1'b0;
    half();
    scl_out = 1'b0;
    half();
  endtask
  task automatic stop();
    sda_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_out = 1'b1;
    half();
  endtask
  // msb first, data changes only while the clock is low
  task automatic wbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_out = b[i];
      half();
      scl_out = 1'b1;
      half();
      scl_out = 1'b0;
      half();
    end
    sda_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    ack = !sda_in;
    scl_out = 1'b0;
    half();
  endtask
endmodule
`default_nettype wire

// ---- dac_ctrl_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module dac_ctrl_test;
  import dac_ctrl_pkg::*;
  logic        clk_in, rst_b_in, a0_in, conv_ready_in, scl_m, sda_m, sda_w;
  logic        sda_out, sda_oe_out, update_out, pd, fast, t1k, t100k, hiz, addr;
  logic [15:0] dac_code_out;
  logic [2:0]  mode_out;
  int          fails, comparisons, upd_cnt;

  // open drain wire with pull-up; the slave's driven level is what it pulls to
  assign sda_w = sda_m & (sda_oe_out ? sda_out : 1'b1);

  dac_ctrl u_dac_ctrl (.clk_in(clk_in), .rst_b_in(rst_b_in), .scl_in(scl_m), .sda_in(sda_w),
    .a0_in(a0_in), .conv_ready_in(conv_ready_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .dac_code_out(dac_code_out), .update_out(update_out), .mode_out(mode_out),
    .powered_down_mode_out(pd), .fast_settle_out(fast), .term_1k_out(t1k),
    .term_100k_out(t100k), .hi_z_out(hiz), .addressed_out(addr));
  i2c_master_model u_i2c_master_model (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl_m), .sda_out(sda_m));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // count update pulses so back-to-back drains are not missed
  always @(posedge clk_in) if (update_out === 1'b1) upd_cnt <= upd_cnt + 1;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [7:0] b, input logic exp);
    logic a;
    u_i2c_master_model.wbyte(b, a);
    check({15'h0, a}, {15'h0, exp});
  endtask
  task automatic frame(input logic [7:0] c, input logic [7:0] m, input logic [7:0] l);
    u_i2c_master_model.start();
    send(8'h98, 1'b1);
    send(c, 1'b1);
    send(m, 1'b1);
    send(l, 1'b1);
    u_i2c_master_model.stop();
  endtask
  // bounded wait: a lost update ends the run
  task automatic wait_upd(input int n);
    int k;
    k = 0;
    while (upd_cnt != n && k < 400) begin
      @(negedge clk_in);
      k++;
    end
    if (upd_cnt != n) begin
      fails++;
      summarize();
    end
  endtask
  task automatic chk_mode(input logic [2:0] m);
    check({13'h0, mode_out}, {13'h0, m});
    check({11'h0, fast, t1k, t100k, hiz, pd}, {11'h0, m == 3'h1, m[2:1] == 2'h1, m[2:1] == 2'h2,
      m[2:1] == 2'h3, m[2:1] != 2'h0});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    comparisons = 0;
    upd_cnt = 0;
    rst_b_in = 1'b0;
    a0_in = 1'b0;
    conv_ready_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_b_in = 1'b1;
    @(negedge clk_in);
    check(dac_code_out, DAC_RESET);
    chk_mode(MODE_LOW_POWER);
    u_i2c_master_model.start();
    send(8'h9a, 1'b0);
    u_i2c_master_model.start();
    send(8'h99, 1'b0);
    u_i2c_master_model.stop();
    // the address follows the select pin
    a0_in = 1'b1;
    u_i2c_master_model.start();
    send(8'h98, 1'b0);
    u_i2c_master_model.start();
    send(8'h9a, 1'b1);
    check({15'h0, addr}, 16'h0001);
    u_i2c_master_model.stop();
    check({15'h0, addr}, 16'h0000);
    a0_in = 1'b0;
    frame(8'h10, 8'h12, 8'h34);
    wait_upd(1);
    check(dac_code_out, 16'h1234);
    // every mode, with junk in the reserved bits
    for (int m = 0; m < 8; m++) begin
      frame(8'h11, {m[2:0], 5'h15}, 8'ha5);
      chk_mode(m[2:0]);
      check(dac_code_out, 16'h1234);
      check(upd_cnt[15:0], 16'h0001);
    end
    frame(8'h10, 8'h56, 8'h78);
    wait_upd(2);
    chk_mode(MODE_LOW_POWER);
    check(dac_code_out, 16'h5678);
    frame(8'h11, 8'h20, 8'h00);
    frame(8'h10, 8'h00, 8'h01);
    wait_upd(3);
    chk_mode(MODE_FAST);
    frame(8'h01, 8'hc0, 8'h00);
    chk_mode(MODE_FAST);
    frame(8'h20, 8'h00, 8'h00);
    chk_mode(3'h6);
    check(dac_code_out, 16'h0001);
    // high speed entry then streamed pairs
    u_i2c_master_model.start();
    send(HS_MASTER_CODE, 1'b0);
    check({15'h0, addr}, 16'h0000);
    u_i2c_master_model.start();
    send(8'h98, 1'b1);
    send(8'h10, 1'b1);
    check({15'h0, addr}, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      send(8'h00, 1'b1);
      send(i[7:0], 1'b1);
      wait_upd(4 + i);
      check(dac_code_out, i[15:0]);
    end
    u_i2c_master_model.stop();
    chk_mode(MODE_LOW_POWER);
    // stall the drain: sixteen words fit, the seventeenth is refused
    conv_ready_in = 1'b0;
    u_i2c_master_model.start();
    send(8'h98, 1'b1);
    send(8'h10, 1'b1);
    for (int i = 0; i < 17; i++) begin
      send(8'h00, 1'b1);
      send(i[7:0], i < 16);
    end
    u_i2c_master_model.stop();
    check(dac_code_out, 16'h0003);
    conv_ready_in = 1'b1;
    wait_upd(23);
    check(dac_code_out, 16'h000f);
    summarize();
  end
endmodule
`default_nettype wire
